/* File: logic/supervisor_pkg.sv */
// constants, state codes and timing counts for the supervisor with watchdog
// Overview of operation
// - reset asserts while level below trip
// - hold reset one hold period after recovery
// - watchdog expiry gives one hold-period reset
// - watchdog counter cleared while reset asserted
// - watchdog counter restarts from zero on release
// - expiry, pulse, restart repeat without kick
// - any kick edge clears counter, 30ns pulses
// - any mode-select edge clears counter
// - extended mode period is base times 500
// - extended mode weakly self-kicks near 94 percent
// - active-high reset is exact inverse
package supervisor_pkg;
    // clock and timing figures
    localparam int CLK_PERIOD_NS = 10;
    localparam int KICK_MIN_PULSE_NS = 30;
    localparam int KICK_MIN_PULSE_CYC = (KICK_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_HOLD_CYC_DEFAULT = 1000;
    localparam int WD_BASE_CYC_DEFAULT = 2000;
    localparam int EXT_FACTOR = 500;
    localparam int SELF_KICK_PCT = 94;
    localparam int CNT_W = 32;
    // reset values
    localparam logic RESET_N_RST = 1'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0;

    // supervisor states, one-hot
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_LOW = 3'h2,
        ST_HOLD = 3'h4
    } sup_state_type;
endpackage : supervisor_pkg

/* File: logic/sync_edge_if.sv */
// synchronised level and edge pulse of one pin
`timescale 1ns/1ps
interface sync_edge_if;
    logic level;
    logic edge_pulse;
    modport source (output level, output edge_pulse);
    modport sink (input level, input edge_pulse);
endinterface : sync_edge_if

/* File: logic/pin_sync_edge.sv */
// two-flop synchroniser with either-edge detection
`timescale 1ns/1ps
module pin_sync_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    sync_edge_if.source sync
);
    logic meta_reg, meta_next;
    logic level_reg, level_next;
    logic prev_reg, prev_next;

    // next values: first flop only feeds the second
    always_comb begin
        meta_next = pin;
        level_next = meta_reg;
        prev_next = level_reg;
    end

    // register stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'h0;
            level_reg <= 1'h0;
            prev_reg <= 1'h0;
        end else begin
            meta_reg <= meta_next;
            level_reg <= level_next;
            prev_reg <= prev_next;
        end
    end

    // edge in either direction, one cycle
    assign sync.level = level_reg;
    assign sync.edge_pulse = level_reg ^ prev_reg;
endmodule : pin_sync_edge

/* File: logic/supervisor_watchdog_reset.sv */
// supervisor: trip-level reset, reset hold timer and watchdog
`timescale 1ns/1ps
module supervisor_watchdog_reset #(
    parameter int RESET_HOLD_CYCLES = supervisor_pkg::RESET_HOLD_CYC_DEFAULT,
    parameter int WD_BASE_CYCLES = supervisor_pkg::WD_BASE_CYC_DEFAULT
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic BELOW_TRIP,
    input wire logic WATCHDOG_KICK_IN,
    input wire logic WATCHDOG_MODE_SELECT,
    output logic WATCHDOG_KICK_OUT,
    output logic WATCHDOG_KICK_OE,
    output logic RESET_OUT_N,
    output logic RESET_OUT
);
    localparam int W = supervisor_pkg::CNT_W;
    localparam int EXT_CYCLES = WD_BASE_CYCLES * supervisor_pkg::EXT_FACTOR;
    localparam int SELF_KICK_CYCLES = EXT_CYCLES / 100 * supervisor_pkg::SELF_KICK_PCT;
    localparam logic [W-1:0] HOLD_LAST = W'(RESET_HOLD_CYCLES - 1);
    localparam logic [W-1:0] BASE_LAST = W'(WD_BASE_CYCLES - 1);
    localparam logic [W-1:0] EXT_LAST = W'(EXT_CYCLES - 1);
    localparam logic [W-1:0] SELF_KICK_AT = W'(SELF_KICK_CYCLES);

    sync_edge_if below_s ();
    sync_edge_if kick_s ();
    sync_edge_if mode_s ();

    // pins pass two flops before any logic reads them
    pin_sync_edge u_below_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .pin(BELOW_TRIP),
        .sync(below_s)
    );
    pin_sync_edge u_kick_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .pin(WATCHDOG_KICK_IN),
        .sync(kick_s)
    );
    pin_sync_edge u_mode_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .pin(WATCHDOG_MODE_SELECT),
        .sync(mode_s)
    );

    supervisor_pkg::sup_state_type state_reg, state_next;
    logic [W-1:0] hold_cnt_reg, hold_cnt_next;
    logic [W-1:0] wd_cnt_reg, wd_cnt_next;
    logic rst_n_reg, rst_n_next;
    logic rst_reg, rst_next;
    logic kick_oe_reg, kick_oe_next;
    logic kick_out_reg, kick_out_next;
    logic [W-1:0] wd_last;
    logic wd_clear;

    // period select and watchdog clear sources
    assign wd_last = mode_s.level ? EXT_LAST : BASE_LAST;
    assign wd_clear = kick_s.edge_pulse | mode_s.edge_pulse;

    // state, counters and output next values
    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        wd_cnt_next = wd_cnt_reg;
        if (below_s.level) begin
            state_next = supervisor_pkg::ST_LOW;
            hold_cnt_next = supervisor_pkg::CNT_RST;
            wd_cnt_next = supervisor_pkg::CNT_RST;
        end else begin
            unique case (state_reg)
                supervisor_pkg::ST_LOW: begin
                    state_next = supervisor_pkg::ST_HOLD;
                    hold_cnt_next = supervisor_pkg::CNT_RST;
                    wd_cnt_next = supervisor_pkg::CNT_RST;
                end
                supervisor_pkg::ST_HOLD: begin
                    wd_cnt_next = supervisor_pkg::CNT_RST;
                    if (hold_cnt_reg >= HOLD_LAST) begin
                        state_next = supervisor_pkg::ST_RUN;
                    end else begin
                        hold_cnt_next = hold_cnt_reg + 1'h1;
                    end
                end
                supervisor_pkg::ST_RUN: begin
                    if (wd_clear) begin
                        wd_cnt_next = supervisor_pkg::CNT_RST;
                    end else if (wd_cnt_reg >= wd_last) begin
                        state_next = supervisor_pkg::ST_HOLD;
                        hold_cnt_next = supervisor_pkg::CNT_RST;
                        wd_cnt_next = supervisor_pkg::CNT_RST;
                    end else begin
                        wd_cnt_next = wd_cnt_reg + 1'h1;
                    end
                end
                default: begin
                    state_next = supervisor_pkg::ST_HOLD;
                    hold_cnt_next = supervisor_pkg::CNT_RST;
                    wd_cnt_next = supervisor_pkg::CNT_RST;
                end
            endcase
        end
        rst_n_next = (state_next == supervisor_pkg::ST_RUN);
        rst_next = ~rst_n_next;
        // weak self-kick only in extended mode while the watchdog runs
        kick_oe_next = mode_s.level && (state_next == supervisor_pkg::ST_RUN);
        kick_out_next = kick_oe_next && (wd_cnt_next >= SELF_KICK_AT);
    end

    // register all state and outputs
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= supervisor_pkg::ST_HOLD;
            hold_cnt_reg <= supervisor_pkg::CNT_RST;
            wd_cnt_reg <= supervisor_pkg::CNT_RST;
            rst_n_reg <= supervisor_pkg::RESET_N_RST;
            rst_reg <= ~supervisor_pkg::RESET_N_RST;
            kick_oe_reg <= 1'h0;
            kick_out_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            wd_cnt_reg <= wd_cnt_next;
            rst_n_reg <= rst_n_next;
            rst_reg <= rst_next;
            kick_oe_reg <= kick_oe_next;
            kick_out_reg <= kick_out_next;
        end
    end

    // outputs straight from flops
    assign RESET_OUT_N = rst_n_reg;
    assign RESET_OUT = rst_reg;
    assign WATCHDOG_KICK_OE = kick_oe_reg;
    assign WATCHDOG_KICK_OUT = kick_out_reg;

    // checks on the design's own behaviour
    property p_below_asserts;
        @(posedge MCLK) disable iff (!NRST)
        below_s.level |=> !RESET_OUT_N && state_reg == supervisor_pkg::ST_LOW;
    endproperty
    a_below_asserts: assert property (p_below_asserts)
        else $error("reset not asserted while below trip");

    property p_recover_starts_hold;
        @(posedge MCLK) disable iff (!NRST)
        (state_reg == supervisor_pkg::ST_LOW && !below_s.level)
            |=> state_reg == supervisor_pkg::ST_HOLD && hold_cnt_reg == '0 && !RESET_OUT_N;
    endproperty
    a_recover_starts_hold: assert property (p_recover_starts_hold)
        else $error("hold period did not start from zero on recovery");

    property p_hold_release;
        @(posedge MCLK) disable iff (!NRST)
        (state_reg == supervisor_pkg::ST_HOLD && hold_cnt_reg == HOLD_LAST && !below_s.level)
            |=> RESET_OUT_N && !RESET_OUT;
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("reset not released at end of hold period");

    property p_hold_not_early;
        @(posedge MCLK) disable iff (!NRST)
        (state_reg == supervisor_pkg::ST_HOLD && hold_cnt_reg < HOLD_LAST) |=> !RESET_OUT_N;
    endproperty
    a_hold_not_early: assert property (p_hold_not_early)
        else $error("reset released before hold period ended");

    property p_wd_expiry;
        @(posedge MCLK) disable iff (!NRST)
        (state_reg == supervisor_pkg::ST_RUN && wd_cnt_reg == wd_last && !wd_clear
            && !below_s.level)
            |=> !RESET_OUT_N && state_reg == supervisor_pkg::ST_HOLD && hold_cnt_reg == '0;
    endproperty
    a_wd_expiry: assert property (p_wd_expiry)
        else $error("watchdog expiry did not start a reset pulse");

    property p_cleared_in_reset;
        @(posedge MCLK) disable iff (!NRST)
        !RESET_OUT_N |-> wd_cnt_reg == '0;
    endproperty
    a_cleared_in_reset: assert property (p_cleared_in_reset)
        else $error("watchdog counter not cleared during reset");

    property p_restart;
        @(posedge MCLK) disable iff (!NRST)
        ($rose(RESET_OUT_N) && !wd_clear && !below_s.level) |=> wd_cnt_reg == 32'h1;
    endproperty
    a_restart: assert property (p_restart)
        else $error("watchdog counter did not restart from zero");

    property p_kick_clears;
        @(posedge MCLK) disable iff (!NRST)
        (state_reg == supervisor_pkg::ST_RUN && kick_s.edge_pulse) |=> wd_cnt_reg == '0;
    endproperty
    a_kick_clears: assert property (p_kick_clears)
        else $error("kick edge did not clear watchdog counter");

    property p_mode_clears;
        @(posedge MCLK) disable iff (!NRST)
        (state_reg == supervisor_pkg::ST_RUN && mode_s.edge_pulse) |=> wd_cnt_reg == '0;
    endproperty
    a_mode_clears: assert property (p_mode_clears)
        else $error("mode edge did not clear watchdog counter");

    property p_normal_period;
        @(posedge MCLK) disable iff (!NRST)
        (!mode_s.level && !$past(mode_s.level)) |-> wd_cnt_reg <= BASE_LAST;
    endproperty
    a_normal_period: assert property (p_normal_period)
        else $error("normal mode counter passed base period");

    property p_self_kick_mode;
        @(posedge MCLK) disable iff (!NRST)
        WATCHDOG_KICK_OUT |-> WATCHDOG_KICK_OE && wd_cnt_reg >= SELF_KICK_AT && $past(mode_s.level);
    endproperty
    a_self_kick_mode: assert property (p_self_kick_mode)
        else $error("self-kick driven outside its window");

    property p_inverse;
        @(posedge MCLK) disable iff (!NRST)
        RESET_OUT == !RESET_OUT_N;
    endproperty
    a_inverse: assert property (p_inverse)
        else $error("active-high reset is not inverse of active-low");

    // main scenarios
    c_wd_expiry: cover property (@(posedge MCLK) disable iff (!NRST)
        state_reg == supervisor_pkg::ST_RUN ##1 state_reg == supervisor_pkg::ST_HOLD);
    c_self_kick: cover property (@(posedge MCLK) disable iff (!NRST) $rose(WATCHDOG_KICK_OUT));
    c_brownout: cover property (@(posedge MCLK) disable iff (!NRST)
        state_reg == supervisor_pkg::ST_LOW ##1 state_reg == supervisor_pkg::ST_HOLD);
    c_kick_in_run: cover property (@(posedge MCLK) disable iff (!NRST)
        state_reg == supervisor_pkg::ST_RUN && kick_s.edge_pulse);
endmodule : supervisor_watchdog_reset

/* File: verif/host_kick_model.sv */
// host side model: toggles or floats the kick pin and resolves the kick wire
`timescale 1ns/1ps
module host_kick_model (
    input wire logic MCLK,
    input wire logic [15:0] GAP,
    input wire logic FLOAT_KICK,
    input wire logic DEV_OE,
    input wire logic DEV_OUT,
    output logic KICK_WIRE
);
    logic drive_reg = 1'h0;
    logic alt_reg = 1'h0;
    logic [15:0] cnt_reg = 16'h0;
    // toggle the strong driver every GAP cycles, never when GAP is zero
    always @(posedge MCLK) begin
        #1;
        alt_reg = ~alt_reg;
        cnt_reg = cnt_reg + 16'h1;
        if (GAP != 16'h0 && cnt_reg >= GAP) begin
            drive_reg = ~drive_reg;
            cnt_reg = 16'h0;
        end
    end
    // a floated pin follows the weak device drive, otherwise it wanders each cycle
    assign KICK_WIRE = !FLOAT_KICK ? drive_reg :
        (DEV_OE ? DEV_OUT : alt_reg);
endmodule : host_kick_model

/* File: verif/test_supervisor_watchdog_reset.sv */
// self-checking bench for the supervisor with watchdog
`timescale 1ns/1ps
module test_supervisor_watchdog_reset;
    localparam int H = 8;
    localparam int W = 20;
    localparam int EXT = W * supervisor_pkg::EXT_FACTOR;
    logic MCLK = 1'h0;
    logic NRST = 1'h0;
    logic below = 1'h0;
    logic mode = 1'h0;
    logic float_kick = 1'h0;
    logic kick_prev = 1'h0;
    logic [15:0] gap = 16'h0;
    logic kick_wire, kick_out, kick_oe, rst_n_out, rst_out;
    int error_cnt = 0;
    int checks_done = 0;
    int n, d, seed;
    int pulses = 0;

    supervisor_watchdog_reset #(.RESET_HOLD_CYCLES(H), .WD_BASE_CYCLES(W)) DUT (
        .MCLK(MCLK), .NRST(NRST), .BELOW_TRIP(below),
        .WATCHDOG_KICK_IN(kick_wire), .WATCHDOG_MODE_SELECT(mode),
        .WATCHDOG_KICK_OUT(kick_out), .WATCHDOG_KICK_OE(kick_oe),
        .RESET_OUT_N(rst_n_out), .RESET_OUT(rst_out));
    host_kick_model host (.MCLK(MCLK), .GAP(gap), .FLOAT_KICK(float_kick),
        .DEV_OE(kick_oe), .DEV_OUT(kick_out), .KICK_WIRE(kick_wire));

    // clock
    initial forever #5 MCLK = ~MCLK;

    // count rising edges of the weak self-kick drive
    always @(posedge MCLK) begin
        if (kick_out === 1'h1 && kick_prev === 1'h0) pulses++;
        kick_prev <= kick_out;
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_int(input string what, input int exp, input int got);
        checks_done++;
        if (got != exp) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_int

    // expected watchdog period in cycles for normal or extended mode
    function automatic int wd_period(input logic ext);
        return ext ? EXT : W;
    endfunction : wd_period

    // one clock, then look at settled outputs
    task automatic tick;
        @(posedge MCLK);
        #1;
        check_bit("reset_inverse", ~rst_n_out, rst_out);
    endtask : tick

    // cycles until the active-low reset shows v, bounded
    task automatic wait_rst(input logic v, input int lim, output int cyc);
        cyc = 0;
        do begin
            tick();
            cyc++;
        end while (rst_n_out !== v && cyc < lim);
    endtask : wait_rst

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // hang guard, well above the expected run length
    initial begin
        #1_000_000;
        error_cnt++;
        summarize();
    end

    initial begin
        seed = $urandom(44969);
        repeat (12) @(posedge MCLK);
        #1 NRST = 1'h1;
        // power-up hold, then repeated expiry without kicks
        wait_rst(1'h1, H + 6, n);
        check_bit("powerup_hold", 1'h1, n >= H && rst_n_out === 1'h1);
        for (int i = 0; i < 2; i++) begin
            wait_rst(1'h0, W + 6, n);
            check_int("wd_period", wd_period(1'h0), n);
            wait_rst(1'h1, H + 6, n);
            check_int("wd_pulse", H, n);
        end
        $display("test watchdog expiry done");
        // random kick spacing keeps reset away
        for (int i = 0; i < 3; i++) begin
            gap = 16'($urandom_range(W - 6, 2));
            wait_rst(1'h0, 3 * W, n);
            check_int("kick_no_reset", 3 * W, n);
            check_bit("kick_oe_normal", 1'h0, kick_oe);
            check_bit("kick_out_normal", 1'h0, kick_out);
        end
        $display("test kicks done");
        // brown-out of random length while kicks go on
        for (int i = 0; i < 3; i++) begin
            d = $urandom_range(30, 1);
            below = 1'h1;
            wait_rst(1'h0, 10, n);
            check_int("trip_delay", 3, n);
            repeat (d) begin
                tick();
                check_bit("held_low", 1'h0, rst_n_out);
            end
            below = 1'h0;
            wait_rst(1'h1, H + 10, n);
            check_int("recover_hold", H + 3, n);
        end
        $display("test brown-out done");
        // mode edges near expiry restart the count
        gap = 16'h0;
        repeat (W - 4) tick();
        mode = 1'h1;
        repeat (30) tick();
        mode = 1'h0;
        wait_rst(1'h0, 3 * W, n);
        check_bit("mode_edge_clears", 1'h1, n >= W);
        wait_rst(1'h1, H + 6, n);
        $display("test mode edges done");
        // extended mode with a steady host drive expires after the long period
        mode = 1'h1;
        wait_rst(1'h0, EXT + 10, n);
        check_bit("ext_period", 1'h1, n >= wd_period(1'h1) && n <= EXT + 5);
        wait_rst(1'h1, H + 6, n);
        $display("test extended period done");
        // extended mode with a floating pin self-kicks and never resets
        float_kick = 1'h1;
        pulses = 0;
        wait_rst(1'h0, 3 * EXT, n);
        check_int("float_no_reset", 3 * EXT, n);
        check_bit("kick_oe_ext", 1'h1, kick_oe);
        check_int("self_kicks", 3, pulses);
        $display("test self kick done");
        summarize();
    end
endmodule : test_supervisor_watchdog_reset
